// ===== src/core_map.svh
// Constant map of the instruction decoder: register addresses, field positions and reset values.
`ifndef CORE_MAP_SVH
`define CORE_MAP_SVH

// Special register addresses in the 32-entry file.
`define ADDR_INDIRECT 5'h00
`define ADDR_TIMER 5'h01
`define ADDR_PC_LOW 5'h02
`define ADDR_STATUS 5'h03
`define ADDR_POINTER 5'h04
`define ADDR_SECOND_IO_PORT 5'h06

// Operand of the direction-load instruction that selects the second port.
`define DIR_PORT_SEL 3'h6

// Status register field positions.
`define ST_CARRY 0
`define ST_HALF_CARRY 1
`define ST_ZERO 2
`define ST_SLEEP 3
`define ST_WDT 4
`define ST_PAGE 5

// Option register field: prescaler goes to the watchdog when this bit is high.
`define OPT_PRESCALER_TO_WDT 3

// Reset values.
`define STATUS_RESET 8'h18
`define OPTION_RESET 8'hff
`define DIRECTION_RESET 8'hff
`define IDLE_WORD 12'h000

// Oscillator periods per instruction cycle and the phase that executes.
`define OSC_PER_CYCLE 4
`define EXEC_PHASE 2'h3

`endif

// ===== src/core_pkg.sv
// Types shared by the decoder core and its arithmetic unit.
package core_pkg;

  // Operation performed by the arithmetic unit.
  typedef enum logic [4:0] {
    OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_COM, OP_INC, OP_DEC, OP_PASS_B,
    OP_PASS_A, OP_ZERO, OP_ROT_L, OP_ROT_R, OP_SWAP, OP_BIT_CLR, OP_BIT_SET
  } alu_op_t;

  // Control class of a decoded instruction.
  typedef enum logic [3:0] {
    CTL_NONE, CTL_CALL, CTL_JUMP, CTL_RETURN, CTL_OPTION, CTL_SLEEP, CTL_KICK,
    CTL_DIRECTION, CTL_TEST_LOW, CTL_TEST_HIGH, CTL_SKIP_ZERO
  } ctl_t;

endpackage

// ===== src/alu_if.sv
// Carrier between the decoder core and its arithmetic unit.
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
  core_pkg::alu_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic [2:0] bsel;
  logic [7:0] result;
  logic c;
  logic dc;
  logic z;
  modport core (output op, a, b, cin, bsel, input result, c, dc, z);
  modport unit (input op, a, b, cin, bsel, output result, c, dc, z);
endinterface
`default_nettype wire

// ===== src/alu_unit.sv
// Combinational arithmetic unit of the decoder core.
`timescale 1ns/1ps
`default_nettype none
module alu_unit (
  alu_if.unit u
);
  logic [8:0] wide;
  logic [4:0] nib;

  ////////////////////////////////////////////////////////////////////////////////
  // Result and flags; half carry only means something for add and subtract, carry also for the rotations.
  always_comb begin
    wide = 9'h000;
    nib = 5'h00;
    u.result = u.b;
    u.c = u.cin;
    case (u.op)
      core_pkg::OP_ADD: begin
        wide = {1'b0, u.b} + {1'b0, u.a};
        nib = {1'b0, u.b[3:0]} + {1'b0, u.a[3:0]};
        u.result = wide[7:0];
        u.c = wide[8];
      end
      core_pkg::OP_SUB: begin
        // Carry reads as not-borrow.
        wide = {1'b0, u.b} - {1'b0, u.a};
        nib = {1'b0, u.b[3:0]} - {1'b0, u.a[3:0]};
        u.result = wide[7:0];
        u.c = ~wide[8];
        nib[4] = ~nib[4];
      end
      core_pkg::OP_AND: u.result = u.a & u.b;
      core_pkg::OP_OR: u.result = u.a | u.b;
      core_pkg::OP_XOR: u.result = u.a ^ u.b;
      core_pkg::OP_COM: u.result = ~u.b;
      core_pkg::OP_INC: u.result = u.b + 8'h01;
      core_pkg::OP_DEC: u.result = u.b - 8'h01;
      core_pkg::OP_PASS_B: u.result = u.b;
      core_pkg::OP_PASS_A: u.result = u.a;
      core_pkg::OP_ZERO: u.result = 8'h00;
      core_pkg::OP_ROT_L: begin
        u.result = {u.b[6:0], u.cin};
        u.c = u.b[7];
      end
      core_pkg::OP_ROT_R: begin
        u.result = {u.cin, u.b[7:1]};
        u.c = u.b[0];
      end
      core_pkg::OP_SWAP: u.result = {u.b[3:0], u.b[7:4]};
      core_pkg::OP_BIT_CLR: u.result = u.b & ~(8'h01 << u.bsel);
      core_pkg::OP_BIT_SET: u.result = u.b | (8'h01 << u.bsel);
      default: u.result = u.b;
    endcase
    u.dc = nib[4];
    u.z = (u.result == 8'h00);
  end
endmodule
`default_nettype wire

// ===== src/instr_core.sv
// Decoder and execution core for 12-bit instruction words on an 8-bit data path.
//
// What this block does
// - Add and subtract combine accumulator and register, updating carry, half carry, zero.
// - Destination bit 0 sends result to accumulator, 1 back to the register.
// - OR, AND, XOR of accumulator and register update only the zero flag.
// - Literal OR, AND, XOR update zero; literal load changes no flags.
// - Increment or decrement and skip next word on zero result; no flags.
// - Rotations through carry change only the carry flag.
// - Bit tests skip the next word when the bit is clear or set.
// - Return loads literal into accumulator, resumes at stacked address with bit eight cleared, two cycles.
// - Every program counter write except the direct jump clears counter bit eight.
// - Standby and watchdog kick take one cycle and update the two status bits.
// - Direction load with operand six copies accumulator into second port enables.
// - A direction bit of one releases the pin, output driver off.
// - Reads of the port register see pin levels, not the output latch.
// - Writing the timer register clears the prescaler when assigned to the timer.
// - Option load copies accumulator into the option register, flags untouched.
// - Bit clear and bit set force one register bit, no flags.
// - An instruction cycle is four clocks; skips and jumps take two cycles.
`timescale 1ns/1ps
`default_nettype none
`include "core_map.svh"
module instr_core #(
  parameter int PC_WIDTH = 10,
  parameter logic [9:0] RESET_VECTOR = 10'h000
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Program memory.
  output logic [PC_WIDTH-1:0] pm_addr_q,
  input wire logic [11:0] pm_data,
  // Second I/O port pins.
  input wire logic [7:0] port_pin,
  output logic [7:0] port_out_q,
  output logic [7:0] port_oe_n_q,
  // Neighbouring blocks.
  output logic [7:0] option_q,
  output logic prescaler_clr_q,
  output logic watchdog_clr_q,
  output logic sleep_req_q
);
  logic [1:0] phase_q;
  logic [11:0] ir_q;
  logic flush_q;
  logic [7:0] acc_q;
  logic [7:0] status_q;
  logic [7:0] file_q [0:31];
  logic [PC_WIDTH-1:0] stack_q [0:1];
  logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q, pins_q;
  alu_if alu ();
  alu_unit u_alu (.u(alu));

  // Decode outputs.
  core_pkg::alu_op_t op;
  core_pkg::ctl_t ctl;
  logic use_lit, wr_acc, wr_reg, upd_z, upd_cdc, upd_c;
  logic exec, skip, branch;
  logic [4:0] addr;
  logic [7:0] reg_rd;
  logic [PC_WIDTH-1:0] pc_q, pc_d;

  assign exec = (phase_q == `EXEC_PHASE);
  assign addr = (ir_q[4:0] == `ADDR_INDIRECT) ? file_q[`ADDR_POINTER][4:0] : ir_q[4:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction decode.
  always_comb begin
    op = core_pkg::OP_PASS_B;
    ctl = core_pkg::CTL_NONE;
    use_lit = 1'b0;
    wr_acc = 1'b0;
    wr_reg = 1'b0;
    upd_z = 1'b0;
    upd_cdc = 1'b0;
    upd_c = 1'b0;
    if (ir_q[11:10] == 2'b00) begin
      // Byte operations route by the destination bit.
      wr_acc = ~ir_q[5];
      wr_reg = ir_q[5];
      upd_z = 1'b1;
      case (ir_q[9:6])
        4'h0: begin
          wr_acc = 1'b0;
          upd_z = 1'b0;
          if (ir_q[5]) begin
            op = core_pkg::OP_PASS_A;
          end else if (ir_q[4:3] == 2'b00) begin
            case (ir_q[2:0])
              3'h2: ctl = core_pkg::CTL_OPTION;
              3'h3: ctl = core_pkg::CTL_SLEEP;
              3'h4: ctl = core_pkg::CTL_KICK;
              3'h5, 3'h6, 3'h7: ctl = core_pkg::CTL_DIRECTION;
              default: ctl = core_pkg::CTL_NONE;
            endcase
          end
        end
        4'h1: op = core_pkg::OP_ZERO;
        4'h2: begin
          op = core_pkg::OP_SUB;
          upd_cdc = 1'b1;
        end
        4'h3: op = core_pkg::OP_DEC;
        4'h4: op = core_pkg::OP_OR;
        4'h5: op = core_pkg::OP_AND;
        4'h6: op = core_pkg::OP_XOR;
        4'h7: begin
          op = core_pkg::OP_ADD;
          upd_cdc = 1'b1;
        end
        4'h8: op = core_pkg::OP_PASS_B;
        4'h9: op = core_pkg::OP_COM;
        4'ha: op = core_pkg::OP_INC;
        4'hb: begin
          op = core_pkg::OP_DEC;
          upd_z = 1'b0;
          ctl = core_pkg::CTL_SKIP_ZERO;
        end
        4'hc: begin
          op = core_pkg::OP_ROT_R;
          upd_z = 1'b0;
          upd_c = 1'b1;
        end
        4'hd: begin
          op = core_pkg::OP_ROT_L;
          upd_z = 1'b0;
          upd_c = 1'b1;
        end
        4'he: begin
          op = core_pkg::OP_SWAP;
          upd_z = 1'b0;
        end
        default: begin
          op = core_pkg::OP_INC;
          upd_z = 1'b0;
          ctl = core_pkg::CTL_SKIP_ZERO;
        end
      endcase
      // Clearing the accumulator has no register operand to write back.
      if (ir_q[9:5] == 5'b00010) begin
        wr_acc = 1'b1;
      end
    end else if (ir_q[11:10] == 2'b01) begin
      case (ir_q[9:8])
        2'b00: begin
          op = core_pkg::OP_BIT_CLR;
          wr_reg = 1'b1;
        end
        2'b01: begin
          op = core_pkg::OP_BIT_SET;
          wr_reg = 1'b1;
        end
        2'b10: ctl = core_pkg::CTL_TEST_LOW;
        default: ctl = core_pkg::CTL_TEST_HIGH;
      endcase
    end else begin
      use_lit = 1'b1;
      case (ir_q[10:8])
        3'h0: begin
          ctl = core_pkg::CTL_RETURN;
          wr_acc = 1'b1;
        end
        3'h1: ctl = core_pkg::CTL_CALL;
        3'h2, 3'h3: ctl = core_pkg::CTL_JUMP;
        3'h4: wr_acc = 1'b1;
        3'h5: begin
          op = core_pkg::OP_OR;
          wr_acc = 1'b1;
          upd_z = 1'b1;
        end
        3'h6: begin
          op = core_pkg::OP_AND;
          wr_acc = 1'b1;
          upd_z = 1'b1;
        end
        default: begin
          op = core_pkg::OP_XOR;
          wr_acc = 1'b1;
          upd_z = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read; the port returns the filtered pin levels.
  always_comb begin
    case (addr)
      `ADDR_PC_LOW: reg_rd = pc_q[7:0];
      `ADDR_STATUS: reg_rd = status_q;
      `ADDR_SECOND_IO_PORT: reg_rd = pins_q;
      default: reg_rd = file_q[addr];
    endcase
  end

  assign alu.op = op;
  assign alu.a = acc_q;
  assign alu.b = use_lit ? ir_q[7:0] : reg_rd;
  assign alu.cin = status_q[`ST_CARRY];
  assign alu.bsel = ir_q[7:5];

  // Skip and branch decisions; both cost a second cycle by flushing the prefetch.
  assign skip = ((ctl == core_pkg::CTL_SKIP_ZERO) && alu.z) ||
    ((ctl == core_pkg::CTL_TEST_LOW) && !reg_rd[ir_q[7:5]]) ||
    ((ctl == core_pkg::CTL_TEST_HIGH) && reg_rd[ir_q[7:5]]);
  assign branch = (ctl == core_pkg::CTL_CALL) || (ctl == core_pkg::CTL_JUMP) ||
    (ctl == core_pkg::CTL_RETURN) || (wr_reg && addr == `ADDR_PC_LOW);

  ////////////////////////////////////////////////////////////////////////////////
  // Next program counter.
  always_comb begin
    pc_d = pc_q + {{(PC_WIDTH-1){1'b0}}, 1'b1};
    case (ctl)
      core_pkg::CTL_JUMP: pc_d = {status_q[`ST_PAGE], ir_q[8:0]};
      core_pkg::CTL_CALL: pc_d = {status_q[`ST_PAGE], 1'b0, ir_q[7:0]};
      core_pkg::CTL_RETURN: pc_d = {stack_q[0][9], 1'b0, stack_q[0][7:0]};
      default: begin
        if (wr_reg && addr == `ADDR_PC_LOW) begin
          pc_d = {status_q[`ST_PAGE], 1'b0, alu.result};
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction cycle of four clocks; work is done on the last one.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // Fetch pipeline; a flushed word executes as the idle word.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pc_q <= RESET_VECTOR;
      ir_q <= `IDLE_WORD;
      flush_q <= 1'b1;
    end else if (exec) begin
      flush_q <= 1'b0;
      ir_q <= pm_data;
      pc_q <= pc_q + {{(PC_WIDTH-1){1'b0}}, 1'b1};
      // The slot after reset runs the idle word, but the word fetched then is kept,
      // so the reset vector is never lost.
      if (!flush_q) begin
        pc_q <= pc_d;
        if (skip || branch) begin
          ir_q <= `IDLE_WORD;
        end
      end
    end
  end

  // Two-level return stack.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stack_q[0] <= '0;
      stack_q[1] <= '0;
    end else if (exec && !flush_q) begin
      if (ctl == core_pkg::CTL_CALL) begin
        stack_q[0] <= pc_q;
        stack_q[1] <= stack_q[0];
      end else if (ctl == core_pkg::CTL_RETURN) begin
        stack_q[0] <= stack_q[1];
      end
    end
  end

  // Accumulator.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= 8'h00;
    end else if (exec && !flush_q && wr_acc) begin
      acc_q <= (ctl == core_pkg::CTL_RETURN) ? ir_q[7:0] : alu.result;
    end
  end

  // Register file writes; the port write lands in the output latch.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 32; i++) begin
        file_q[i] <= 8'h00;
      end
      port_out_q <= 8'h00;
    end else if (exec && !flush_q && wr_reg) begin
      file_q[addr] <= alu.result;
      if (addr == `ADDR_SECOND_IO_PORT) begin
        port_out_q <= alu.result;
      end
    end
  end

  // Status flags; a write to the status register leaves the two power bits alone.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= `STATUS_RESET;
    end else if (exec && !flush_q) begin
      if (wr_reg && addr == `ADDR_STATUS) begin
        status_q <= {alu.result[7:5], status_q[4:3], alu.result[2:0]};
      end
      if (upd_z) begin
        status_q[`ST_ZERO] <= alu.z;
      end
      if (upd_cdc) begin
        status_q[`ST_CARRY] <= alu.c;
        status_q[`ST_HALF_CARRY] <= alu.dc;
      end
      if (upd_c) begin
        status_q[`ST_CARRY] <= alu.c;
      end
      if (ctl == core_pkg::CTL_SLEEP) begin
        status_q[`ST_WDT] <= 1'b1;
        status_q[`ST_SLEEP] <= 1'b0;
      end else if (ctl == core_pkg::CTL_KICK) begin
        status_q[`ST_WDT] <= 1'b1;
        status_q[`ST_SLEEP] <= 1'b1;
      end
    end
  end

  // Option and direction latches; direction bits drive the enables directly.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      option_q <= `OPTION_RESET;
      port_oe_n_q <= `DIRECTION_RESET;
    end else if (exec && !flush_q) begin
      if (ctl == core_pkg::CTL_OPTION) begin
        option_q <= acc_q;
      end
      if (ctl == core_pkg::CTL_DIRECTION && ir_q[2:0] == `DIR_PORT_SEL) begin
        port_oe_n_q <= acc_q;
      end
    end
  end

  // One-clock pulses to the timer, watchdog and power blocks.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prescaler_clr_q <= 1'b0;
      watchdog_clr_q <= 1'b0;
      sleep_req_q <= 1'b0;
    end else begin
      prescaler_clr_q <= exec && !flush_q && wr_reg && addr == `ADDR_TIMER &&
        !option_q[`OPT_PRESCALER_TO_WDT];
      watchdog_clr_q <= exec && !flush_q && ctl == core_pkg::CTL_KICK;
      sleep_req_q <= exec && !flush_q && ctl == core_pkg::CTL_SLEEP;
    end
  end

  // Pin synchroniser; a level is taken only when the second and third stages agree.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      pin_s3_q <= 8'h00;
      pins_q <= 8'h00;
    end else begin
      pin_s1_q <= port_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pins_q <= (pin_s2_q & pin_s3_q) | (pins_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  assign pm_addr_q = pc_q;
endmodule
`default_nettype wire

// ===== tb/prog_mem_model.sv
// Program memory model that supplies instruction words to the core.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  // Fetch port.
  input wire logic [9:0] addr,
  output logic [11:0] data
);
  logic [11:0] mem [0:1023];
  // Asynchronous read: the word must be valid well before the core's exec edge.
  assign data = mem[addr];
endmodule
`default_nettype wire

// ===== tb/instr_core_asserts.sv
// Timing checker for the ports of the instruction core.
`timescale 1ns/1ps
`default_nettype none
module instr_core_asserts #(
  parameter int PC_WIDTH = 10,
  parameter logic [9:0] RESET_VECTOR = 10'h000
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Observed outputs.
  input wire logic [PC_WIDTH-1:0] pm_addr_q,
  input wire logic [7:0] port_out_q,
  input wire logic [7:0] port_oe_n_q,
  input wire logic [7:0] option_q,
  input wire logic prescaler_clr_q,
  input wire logic watchdog_clr_q,
  input wire logic sleep_req_q
);
  logic [1:0] phase_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Mirror of the four-clock cycle phase; the exec edge is where it reads 3.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  pc_hold_a: assert property (phase_q != 2'h3 |=> $stable(pm_addr_q))
    else $error("program address moved off the exec edge");
  latch_hold_a: assert property (phase_q != 2'h3 |=>
    $stable({option_q, port_out_q, port_oe_n_q})) else $error("latch moved off exec edge");
  reset_value_a: assert property ($rose(arst_n) |-> pm_addr_q == RESET_VECTOR &&
    option_q == 8'hff && port_oe_n_q == 8'hff && port_out_q == 8'h00)
    else $error("bad value after reset");
  first_fetch_a: assert property ($rose(arst_n) |-> ##3 pm_addr_q == RESET_VECTOR
    ##1 pm_addr_q == RESET_VECTOR + 10'h001) else $error("first fetch mistimed");
  sleep_pulse_a: assert property (sleep_req_q |=> !sleep_req_q [*3])
    else $error("standby pulse too long");
  kick_pulse_a: assert property (watchdog_clr_q |=> !watchdog_clr_q [*3])
    else $error("watchdog pulse too long");
  pulse_excl_a: assert property (!(sleep_req_q && watchdog_clr_q))
    else $error("two pulses at once");
  pulse_phase_a: assert property (sleep_req_q || watchdog_clr_q |->
    phase_q inside {2'h0, 2'h1}) else $error("pulse out of phase");
  clear_owner_a: assert property (prescaler_clr_q |->
    !option_q[3] && !$past(prescaler_clr_q)) else $error("bad prescaler clear");
  // Main scenarios reached.
  cover property ($rose(sleep_req_q));
  cover property ($rose(watchdog_clr_q));
  cover property ($rose(prescaler_clr_q));
endmodule
bind instr_core instr_core_asserts #(.PC_WIDTH(PC_WIDTH), .RESET_VECTOR(RESET_VECTOR)) u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .pm_addr_q(pm_addr_q), .port_out_q(port_out_q),
  .port_oe_n_q(port_oe_n_q), .option_q(option_q), .prescaler_clr_q(prescaler_clr_q),
  .watchdog_clr_q(watchdog_clr_q), .sleep_req_q(sleep_req_q));
`default_nettype wire

// ===== tb/test_instr_core.sv
// Self-checking bench: runs a generated program and checks published results.
`timescale 1ns/1ps
`default_nettype none
module test_instr_core;
  logic clk_sys, arst_n, prescaler_clr_q, watchdog_clr_q, sleep_req_q, d, skip;
  logic [9:0] pm_addr_q;
  logic [11:0] pm_data;
  logic [7:0] port_pin, port_out_q, port_oe_n_q, option_q, w, f, r, v, oe;
  logic [2:0] b;
  logic c, dc, z;
  logic [7:0] exp_q[$];
  int pc, fin, i, k, n, n_pre, n_kick, error_cnt, samples_checked;
  logic [11:0] base [16] = '{12'h1c0, 12'h080, 12'h140, 12'h100, 12'h180, 12'h340,
    12'h300, 12'h380, 12'h240, 12'h280, 12'h0c0, 12'h200, 12'hd00, 12'he00, 12'hf00, 12'hc00};
  instr_core #(.PC_WIDTH(10), .RESET_VECTOR(10'h000)) u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .pm_addr_q(pm_addr_q), .pm_data(pm_data),
    .port_pin(port_pin), .port_out_q(port_out_q), .port_oe_n_q(port_oe_n_q),
    .option_q(option_q), .prescaler_clr_q(prescaler_clr_q),
    .watchdog_clr_q(watchdog_clr_q), .sleep_req_q(sleep_req_q));
  prog_mem_model u_pm (.addr(pm_addr_q), .data(pm_data));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic emit(input logic [11:0] word);
    u_pm.mem[pc] = word;
    pc++;
  endtask
  // The core has no accumulator output of its own, so each result is
  // copied through an option load and marked by a standby pulse.
  task automatic publish(input logic [7:0] val);
    emit(12'h002);
    emit(12'h003);
    exp_q.push_back(val);
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Reference arithmetic; updates the flag model as the core should.
  function automatic logic [7:0] alu(input int op, input logic [7:0] a, input logic [7:0] m);
    logic [8:0] s;
    logic [7:0] res;
    s = {1'b0, m} + {1'b0, a};
    case (op)
      0: begin res = s[7:0]; c = s[8]; dc = (m[3:0] + a[3:0]) > 15; end
      1: begin res = m - a; c = m >= a; dc = m[3:0] >= a[3:0]; end
      2, 13: res = m & a;
      3, 12: res = m | a;
      4, 14: res = m ^ a;
      5: begin res = {m[6:0], c}; c = m[7]; end
      6: begin res = {c, m[7:1]}; c = m[0]; end
      7: res = {m[3:0], m[7:4]};
      8: res = ~m;
      9: res = m + 8'h01;
      10: res = m - 8'h01;
      default: res = m;
    endcase
    if (!(op inside {5, 6, 7, 15})) z = (res == 8'h00);
    return res;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Result monitor: each standby pulse retires the oldest expected value.
  always @(posedge clk_sys) begin
    n_pre += (prescaler_clr_q === 1'b1);
    n_kick += (watchdog_clr_q === 1'b1);
    if (sleep_req_q === 1'b1) begin
      check(option_q, exp_q.size() > 0 ? exp_q.pop_front() : ~option_q);
    end
  end
  // Hang guard, sized well above the program's run time.
  initial begin
    #500000;
    error_cnt++;
    summarize();
  end
  // Program build, reset and final checks.
  initial begin
    void'($urandom(32'hab2c));
    arst_n = 1'b0;
    port_pin = {7'($urandom), 1'b0};
    {c, dc, z} = 3'h0;
    for (int a = 0; a < 1024; a++) u_pm.mem[a] = 12'h000;
    u_pm.mem[0] = 12'ha04;
    u_pm.mem[1] = 12'h85a;
    pc = 4;
    emit(12'h901);
    publish(8'h5a);
    emit(12'hcff); emit(12'h026); emit(12'h506); emit(12'h206);
    publish(port_pin);
    emit(12'hc00); emit(12'h002); emit(12'hc05); emit(12'h021);
    emit(12'hc08); emit(12'h002); emit(12'h061);
    emit(12'hc00); emit(12'h002); emit(12'h061);
    z = 1'b1;
    oe = $urandom;
    emit({4'hc, oe}); emit(12'h006); emit(12'hc5a); emit(12'h005);
    emit(12'h004); emit(12'h004);
    for (int it = 0; it < 32; it++) begin
      i = it % 16;
      w = $urandom;
      f = $urandom;
      d = (i < 12) ? 1'($urandom_range(0, 1)) : 1'b0;
      emit({4'hc, f}); emit(12'h030); emit({4'hc, w});
      r = alu(i, w, f);
      emit(i < 12 ? base[i] | {6'h00, d, 5'h10} : base[i] | {4'h0, f});
      if (!d) emit(12'h031);
      emit(12'h203); emit(12'he07);
      publish({5'h00, z, dc, c});
      z = ({z, dc, c} == 3'h0);
      emit(d ? 12'h210 : 12'h211);
      publish(r);
      // The read-back move sets the zero flag from the result.
      z = (r == 8'h00);
    end
    for (int it = 0; it < 8; it++) begin
      k = it % 4;
      b = 3'($urandom_range(0, 7));
      v = (k == 0) ? 8'($urandom_range(0, 2)) : (k == 1) ? 8'hfd + 8'($urandom_range(0, 2)) : 8'($urandom);
      skip = (k == 0) ? v == 8'h01 : (k == 1) ? v == 8'hff : (k == 2) ? !v[b] : v[b];
      emit({4'hc, v}); emit(12'h032); emit(12'hc3c);
      emit(k < 2 ? (k == 1 ? 12'h3f2 : 12'h2f2) : {3'b011, k == 3, b, 5'h12});
      emit(12'hc55);
      publish(skip ? 8'h3c : 8'h55);
    end
    // Bit clear on a full register, then clearing the accumulator.
    b = 3'($urandom);
    emit(12'hcff); emit(12'h033); emit({4'h4, b, 5'h13}); emit(12'h213);
    publish(~(8'h01 << b));
    emit(12'h040);
    publish(8'h00);
    emit(12'hc02); emit(12'h022);
    u_pm.mem[2] = {3'b101, 9'(pc)};
    emit(12'hc42);
    emit({3'b101, 9'(pc + 3)}); emit(12'hc99); emit(12'hc98);
    publish(8'h42);
    fin = pc;
    emit({3'b101, 9'(pc)});
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (n = 0; n < 12000 && pm_addr_q !== 10'(fin); n++) @(posedge clk_sys);
    repeat (12) @(posedge clk_sys);
    check(8'(n < 12000), 8'h01);
    check(8'(exp_q.size()), 8'h00);
    check(port_out_q, port_pin | 8'h01);
    check(port_oe_n_q, oe);
    check(8'(n_pre), 8'h02);
    check(8'(n_kick), 8'h02);
    summarize();
  end
endmodule
`default_nettype wire
